// *** dv/dcc_analog_model.sv ***
// Analog levels, comparator results and pin loads around the block
`timescale 1ns/10ps
module dcc_analog_model (
   input wire logic [3:0][7:0] lvl, // Levels, pins three..zero
   input wire logic [7:0] vref,     // Internal reference level
   input wire logic [5:0] ext,      // Outside drive of released pins
   input wire logic cmp_power,      // Comparators powered
   input wire logic vref_to_pos,    // Reference on positive inputs
   input wire logic neg_input_alt,  // Negatives on pins three, two
   input wire logic [5:0] pin_out,  // Block drive levels
   input wire logic [5:0] pin_oe,   // Block drive enables
   output logic cmp_one_raw,        // Result, comparator one
   output logic cmp_two_raw,        // Result, comparator two
   output logic [5:0] pin_in        // Resolved pin levels
);
   logic [7:0] pos1, pos2, neg1, neg2;
   logic sw;
   ////////////////////////////////////////////////////////////////////
   // Input routing; equal levels give a low result
   always_comb begin
      sw = vref_to_pos && neg_input_alt;
      pos1 = vref_to_pos ? vref : lvl[3];
      pos2 = vref_to_pos ? vref : lvl[2];
      neg1 = sw ? lvl[3] : lvl[0];
      neg2 = sw ? lvl[2] : lvl[1];
      cmp_one_raw = cmp_power && (pos1 > neg1);
      cmp_two_raw = cmp_power && (pos2 > neg2);
   end
   ////////////////////////////////////////////////////////////////////
   // Released pin four floats high through its pull-up
   always_comb begin
      pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
      pin_in[4] = pin_oe[4] ? pin_out[4] : 1'b1;
   end
endmodule

// *** dv/tb.sv ***
// Self-checking testbench of the comparator control block
`timescale 1ns/10ps
`include "dcc_map.svh"
module tb;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic c1, c2, irq, wake_req, cmp_power, vref_to_pos, neg_input_alt;
   logic [5:0] pin_in, pin_out, pin_oe, ext;
   logic [3:0] analog_mask, cv;
   logic [3:0][7:0] lvl;
   logic [7:0] vref;
   logic e1, e2;
   int n_mismatch, total_checks;
   dcc_top #(.ADDR_W(12)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp_one_raw(c1), .cmp_two_raw(c2),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq),
      .wake_req(wake_req), .cmp_power(cmp_power),
      .vref_to_pos(vref_to_pos), .neg_input_alt(neg_input_alt),
      .analog_mask(analog_mask));
   dcc_analog_model u_model (.lvl(lvl), .vref(vref), .ext(ext),
      .cmp_power(cmp_power), .vref_to_pos(vref_to_pos),
      .neg_input_alt(neg_input_alt), .pin_out(pin_out), .pin_oe(pin_oe),
      .cmp_one_raw(c1), .cmp_two_raw(c2), .pin_in(pin_in));
   ////////////////////////////////////////////////////////////////////
   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [9:0] idx,
                      input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp,
                        input string name);
      apb(1'b0, idx, 8'h00);
      chk(name, rd, exp);
   endtask
   // Levels for pins three..zero giving the wanted raw results
   task automatic set_raw(input logic one, input logic two);
      lvl <= {one ? 8'hC8 : 8'h64, two ? 8'hC8 : 8'h64, 8'h96, 8'h96};
      repeat (6) @(posedge pclk);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // Clock and watchdog; the tests need well under 5000 cycles
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      #(50 * 20000);
      n_mismatch++;
      summarize();
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      ext = 6'h3F;
      vref = 8'h96;
      lvl = {8'h64, 8'h64, 8'h96, 8'h96};
      n_mismatch = 0;
      total_checks = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(`DCC_IDX_CMP, 32'h07, "control");
      rdchk(`DCC_IDX_INTM, 32'h00, "intm");
      rdchk(`DCC_IDX_FLG2, 32'h00, "flags");
      rdchk(`DCC_IDX_DIR, 32'h3F, "dir");
      chk("power", cmp_power, 32'h0);
      rdchk(`DCC_IDX_PORT, 32'h3F, "port off");
      apb(1'b0, 10'h001, 8'h00);
      chk("unmapped err", err, 32'h1);
      chk("unmapped data", rd, 32'h0);
      $display("test reset done");
      // Every mode: power and reference routing
      for (int m = 0; m < 8; m++) begin
         apb(1'b1, `DCC_IDX_CMP, {5'h00, m[2:0]});
         repeat (2) @(posedge pclk);
         chk("power", cmp_power, 32'(m != 7));
         chk("vref", vref_to_pos, 32'(m == 6));
      end
      $display("test modes done");
      // Inversions, read-only results and pin routing in mode 011
      for (int i = 0; i < 16; i++) begin
         cv = i[3:0];
         apb(1'b1, `DCC_IDX_CMP, {2'b11, cv[3:2], 4'h3});
         set_raw(cv[1], cv[0]);
         e2 = cv[0] ^ cv[3];
         e1 = cv[1] ^ cv[2];
         rdchk(`DCC_IDX_CMP, {24'h0,e2,e1,cv[3:2],4'h3}, "ctl");
         chk("pins", pin_out[5:4], {30'h0, e2, e1});
      end
      chk("mask", analog_mask, 32'hF);
      apb(1'b1, `DCC_IDX_DIR, 8'h0F);
      repeat (2) @(posedge pclk);
      chk("oe", pin_oe, 32'h30);
      rdchk(`DCC_IDX_PORT, 32'h00, "port");
      // Port latch drives the low pin levels; visible from the write edge, checked one edge later
      apb(1'b1, `DCC_IDX_PORT, 8'h0A);
      @(posedge pclk);
      chk("latch", pin_out[3:0], 32'hA);
      apb(1'b1, `DCC_IDX_DIR, 8'h3F);
      $display("test outputs done");
      // Reference mode with both switch settings
      lvl <= {8'hC8, 8'hC8, 8'h64, 8'h64};
      apb(1'b1, `DCC_IDX_CMP, 8'h06);
      repeat (5) @(posedge pclk);
      rdchk(`DCC_IDX_CMP, 32'hC6, "ref sw0");
      chk("alt", neg_input_alt, 32'h0);
      apb(1'b1, `DCC_IDX_CMP, 8'h0E);
      repeat (5) @(posedge pclk);
      rdchk(`DCC_IDX_CMP, 32'h0E, "ref sw1");
      chk("alt", neg_input_alt, 32'h1);
      $display("test reference done");
      // Change interrupt; enables set only after the mode change
      apb(1'b1, `DCC_IDX_CMP, 8'h03);
      set_raw(1'b0, 1'b0);
      apb(1'b1, `DCC_IDX_INTM, 8'hC0);
      apb(1'b1, `DCC_IDX_ENA2, 8'h40);
      apb(1'b0, `DCC_IDX_CMP, 8'h00);
      apb(1'b1, `DCC_IDX_FLG2, 8'h00);
      rdchk(`DCC_IDX_FLG2, 32'h00, "flag clear");
      chk("irq", irq, 32'h0);
      // Clock enable low freezes detection and the request
      ce <= 1'b0;
      set_raw(1'b1, 1'b0);
      chk("ce freeze", irq, 32'h0);
      ce <= 1'b1;
      set_raw(1'b1, 1'b0);
      rdchk(`DCC_IDX_FLG2, 32'h40, "flag set");
      chk("irq", irq, 32'h1);
      chk("wake", wake_req, 32'h1);
      apb(1'b1, `DCC_IDX_FLG2, 8'h00);
      rdchk(`DCC_IDX_FLG2, 32'h40, "flag stuck");
      apb(1'b0, `DCC_IDX_CMP, 8'h00);
      apb(1'b1, `DCC_IDX_FLG2, 8'h00);
      rdchk(`DCC_IDX_FLG2, 32'h00, "flag cleared");
      repeat (2) @(posedge pclk);
      chk("irq", irq, 32'h0);
      apb(1'b1, `DCC_IDX_FLG2, 8'h40);
      rdchk(`DCC_IDX_FLG2, 32'h40, "flag soft");
      repeat (2) @(posedge pclk);
      chk("irq soft", irq, 32'h1);
      apb(1'b1, `DCC_IDX_FLG2, 8'h00);
      apb(1'b1, `DCC_IDX_INTM, 8'h40);
      rdchk(`DCC_IDX_INTM, 32'h40, "intm");
      set_raw(1'b0, 1'b0);
      rdchk(`DCC_IDX_FLG2, 32'h40, "flag no gie");
      chk("irq", irq, 32'h0);
      chk("wake", wake_req, 32'h1);
      rdchk(`DCC_IDX_CMP, 32'h03, "ctl kept");
      apb(1'b1, `DCC_IDX_ENA2, 8'h00);
      repeat (2) @(posedge pclk);
      chk("wake off", wake_req, 32'h0);
      // Comparators off before a sleep
      apb(1'b1, `DCC_IDX_CMP, 8'h07);
      repeat (2) @(posedge pclk);
      chk("power off", cmp_power, 32'h0);
      $display("test interrupt done");
      summarize();
   end
endmodule

// *** hw/dcc_route.sv ***
// Mode decoder for comparator input and output routing
`timescale 1ns/10ps
`include "dcc_map.svh"
module dcc_route (
   input wire dcc_pkg::dcc_mode_t mode, // Routing mode field
   input wire logic sw,                 // Negative input switch
   output logic cmp_on,                 // Comparators powered
   output logic vref_pos,               // Reference on positive inputs
   output logic neg_alt,                // Negatives on pins three, two
   output logic [3:0] an_mask,          // Pins zero..three analog
   output logic pin_route               // Results onto pins four, five
);
   localparam logic [7:0] PIN_MODES = `DCC_PIN_OUT_MODES;

   // Pure decode; the caller registers the results
   always_comb begin
      cmp_on = (mode != dcc_pkg::DCC_M_OFF);
      vref_pos = (mode == dcc_pkg::DCC_M_REF);
      neg_alt = (mode == dcc_pkg::DCC_M_REF) && sw;
      an_mask = cmp_on ? 4'hF : 4'h0;
      pin_route = PIN_MODES[mode];
   end
endmodule

// *** hw/dcc_sync.sv ***
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/10ps
module dcc_sync #(
   parameter int W = 2
) (
   input wire logic clk,        // Clock
   input wire logic rst_n,      // Async reset, active low
   input wire logic ce,         // Clock enable
   input wire logic [W-1:0] d,  // Asynchronous input
   output logic [W-1:0] q       // Synchronised output
);
   typedef struct packed {
      logic [W-1:0] m1;
      logic [W-1:0] m2;
   } dcc_sync_t;
   dcc_sync_t st, next_st;

   if (W < 1) begin : g_chk
      $error("dcc_sync: W must be at least 1");
   end

   // First stage feeds only the second
   always_comb begin
      next_st = st;
      if (ce) begin
         next_st.m1 = d;
         next_st.m2 = st.m1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.m2;
endmodule

// *** hw/dcc_top.sv ***
// Comparator control, status and change-interrupt logic with APB access
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`include "dcc_map.svh"
module dcc_top #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,                 // Bus clock, 20 MHz
   input wire logic presetn,              // Async reset, active low
   input wire logic ce,                   // Clock enable, freezes state
   input wire logic psel,                 // APB select
   input wire logic penable,              // APB enable
   input wire logic pwrite,               // APB direction
   input wire logic [ADDR_W-1:0] paddr,   // APB byte address
   input wire logic [31:0] pwdata,        // APB write data
   output logic [31:0] prdata,            // APB read data
   output logic pready,                   // APB ready
   output logic pslverr,                  // APB error
   input wire logic cmp_one_raw,          // Analog result, comparator one
   input wire logic cmp_two_raw,          // Analog result, comparator two
   input wire logic [5:0] pin_in,         // Port pin levels
   output logic [5:0] pin_out,            // Port pin drive levels
   output logic [5:0] pin_oe,             // Port pin drive enables
   output logic irq,                      // Interrupt request
   output logic wake_req,                 // Wake from sleep
   output logic cmp_power,                // Comparators powered
   output logic vref_to_pos,              // Reference on positive inputs
   output logic neg_input_alt,            // Negatives on pins three, two
   output logic [3:0] analog_mask         // Pins zero..three analog
);
   typedef struct packed {
      logic two_inv;
      logic one_inv;
      logic sw;
      dcc_pkg::dcc_mode_t mode;
      logic [7:0] intm;
      logic flag;
      logic ena;
      logic [5:0] dir;
      logic [5:0] lat;
      logic [1:0] seen;
      logic [7:0] rdata;
      logic rdy;
      logic err;
      logic irq;
      logic wake;
      logic pwr;
      logic vpos;
      logic nalt;
      logic [3:0] amask;
      logic route;
      logic [5:0] oe;
   } dcc_state_t;
   dcc_state_t st, next_st;

   if (ADDR_W < 12) begin : g_chk
      $error("dcc_top: ADDR_W must be at least 12");
   end

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers and mode decode

   logic [1:0] res_s;
   logic [5:0] pin_s;
   logic d_pwr, d_vpos, d_nalt, d_route;
   logic [3:0] d_amask;

   dcc_sync #(.W(2)) u_res_sync (
      .clk(pclk),
      .rst_n(presetn),
      .ce(ce),
      .d({cmp_two_raw, cmp_one_raw}),
      .q(res_s)
   );

   dcc_sync #(.W(6)) u_pin_sync (
      .clk(pclk),
      .rst_n(presetn),
      .ce(ce),
      .d(pin_in),
      .q(pin_s)
   );

   dcc_route u_route (
      .mode(st.mode),
      .sw(st.sw),
      .cmp_on(d_pwr),
      .vref_pos(d_vpos),
      .neg_alt(d_nalt),
      .an_mask(d_amask),
      .pin_route(d_route)
   );

   ////////////////////////////////////////////////////////////////////////
   // Result polarity and mismatch detection

   logic [1:0] cur;
   logic one_res, two_res, mism, set_req;
   logic [9:0] idx;
   logic bad_addr, setup, acc, wr, cmp_acc;

   // Synchronised results are taken as low while the comparators are off
   assign cur = st.pwr ? res_s : 2'b00;
   assign one_res = cur[0] ^ st.one_inv;
   assign two_res = cur[1] ^ st.two_inv;

   assign idx = paddr[11:2];
   assign bad_addr = (paddr[1:0] != 2'b00) || ((paddr >> 12) != '0);
   assign setup = psel && !penable && !st.rdy;
   assign acc = psel && penable && st.rdy;
   assign wr = acc && pwrite && !st.err;
   assign cmp_acc = acc && !st.err && (idx == `DCC_IDX_CMP);

   // Compared every cycle; a control register access in the same cycle hides the change
   assign mism = (cur != st.seen);
   assign set_req = mism && !cmp_acc;

   ////////////////////////////////////////////////////////////////////////
   // Next state

   logic [7:0] rd;
   logic rd_err;

   always_comb begin
      next_st = st;
      rd = 8'h00;
      rd_err = 1'b0;
      // Address decode in the setup cycle
      if (bad_addr) begin
         rd_err = 1'b1;
      end else if (idx == `DCC_IDX_PORT) begin
         rd = {2'b00, pin_s & ~{2'b00, st.amask}};
      end else if (idx == `DCC_IDX_INTM) begin
         rd = st.intm;
      end else if (idx == `DCC_IDX_FLG2) begin
         rd[`DCC_B_FLAG] = st.flag;
      end else if (idx == `DCC_IDX_DIR) begin
         rd = {2'b00, st.dir};
      end else if (idx == `DCC_IDX_ENA2) begin
         rd[`DCC_B_ENA] = st.ena;
      end else if (idx == `DCC_IDX_CMP) begin
         rd = {two_res, one_res, st.two_inv, st.one_inv, st.sw, st.mode};
      end else begin
         rd_err = 1'b1;
      end
      if (ce) begin
         // No wait state: ready raised at the setup edge
         next_st.rdy = setup;
         if (setup) begin
            next_st.rdata = pwrite ? 8'h00 : rd;
            next_st.err = rd_err;
         end else begin
            next_st.err = 1'b0;
         end
         if (wr && idx == `DCC_IDX_INTM) begin
            next_st.intm = pwdata[7:0];
         end
         if (wr && idx == `DCC_IDX_PORT) begin
            next_st.lat = pwdata[5:0];
         end
         if (wr && idx == `DCC_IDX_DIR) begin
            next_st.dir = pwdata[5:0];
         end
         if (wr && idx == `DCC_IDX_ENA2) begin
            next_st.ena = pwdata[`DCC_B_ENA];
         end
         // Result bits are not written: they track the comparators
         if (wr && idx == `DCC_IDX_CMP) begin
            next_st.two_inv = pwdata[`DCC_B_TWO_INV];
            next_st.one_inv = pwdata[`DCC_B_ONE_INV];
            next_st.sw = pwdata[`DCC_B_SWITCH];
            next_st.mode = dcc_pkg::dcc_mode_t'(pwdata[2:0]);
         end
         // Any control access relatches and ends the mismatch
         if (cmp_acc) begin
            next_st.seen = cur;
         end
         // Hardware set wins over a software clear
         if (set_req) begin
            next_st.flag = 1'b1;
         end else if (wr && idx == `DCC_IDX_FLG2) begin
            next_st.flag = pwdata[`DCC_B_FLAG];
         end
         // Registered views; flag sets even with enables clear
         next_st.irq = st.flag && st.ena && st.intm[`DCC_B_PERIPHERAL_IRQ_ENABLE]
            && st.intm[`DCC_B_GIE];
         next_st.wake = st.flag && st.ena && st.intm[`DCC_B_PERIPHERAL_IRQ_ENABLE];
         next_st.pwr = d_pwr;
         next_st.vpos = d_vpos;
         next_st.nalt = d_nalt;
         next_st.amask = d_amask;
         next_st.route = d_route;
         next_st.oe = ~st.dir;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; reset lands in the comparators-off mode

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.mode <= dcc_pkg::dcc_mode_t'(3'(`DCC_RST_CMP));
         st.intm <= `DCC_RST_INTM;
         st.dir <= `DCC_RST_DIR;
         st.lat <= `DCC_RST_PORT;
         st.oe <= ~`DCC_RST_DIR;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign prdata = {24'h000000, st.rdata};
   assign pready = st.rdy;
   assign pslverr = st.err;
   assign irq = st.irq;
   assign wake_req = st.wake;
   assign cmp_power = st.pwr;
   assign vref_to_pos = st.vpos;
   assign neg_input_alt = st.nalt;
   assign analog_mask = st.amask;
   assign pin_oe = st.oe;

   // Routed results skip the synchroniser, so pins follow the analog edge
   always_comb begin
      pin_out = st.lat;
      if (st.route) begin
         pin_out[`DCC_PIN_FOUR] = cmp_one_raw ^ st.one_inv;
         pin_out[`DCC_PIN_FIVE] = cmp_two_raw ^ st.two_inv;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   logic rd_cmp_setup, rd_port_setup;
   assign rd_cmp_setup = setup && !pwrite && !bad_addr
      && idx == `DCC_IDX_CMP && ce;
   assign rd_port_setup = setup && !pwrite && !bad_addr
      && idx == `DCC_IDX_PORT && ce;

   property p_two_status;
      @(posedge pclk) disable iff (!presetn)
      rd_cmp_setup |=> prdata[7] == $past(cur[1] ^ st.two_inv);
   endproperty
   a_two_status: assert property (p_two_status)
      else $error("result two status wrong");

   property p_one_status;
      @(posedge pclk) disable iff (!presetn)
      rd_cmp_setup |=> prdata[6] == $past(cur[0] ^ st.one_inv);
   endproperty
   a_one_status: assert property (p_one_status)
      else $error("result one status wrong");

   property p_mode_write;
      @(posedge pclk) disable iff (!presetn)
      (ce && wr && idx == `DCC_IDX_CMP) |=> st.mode == $past(pwdata[2:0])
         && !pready;
   endproperty
   a_mode_write: assert property (p_mode_write)
      else $error("mode field not written");

   property p_ref_mode;
      @(posedge pclk) disable iff (!presetn)
      (ce && st.mode == dcc_pkg::DCC_M_REF) |=> vref_to_pos
         && neg_input_alt == $past(st.sw);
   endproperty
   a_ref_mode: assert property (p_ref_mode)
      else $error("reference mode routing wrong");

   property p_port_analog;
      @(posedge pclk) disable iff (!presetn)
      rd_port_setup |=> (prdata[3:0] & $past(st.amask)) == 4'h0;
   endproperty
   a_port_analog: assert property (p_port_analog)
      else $error("analog pin read nonzero");

   property p_flag_set;
      @(posedge pclk) disable iff (!presetn)
      (ce && mism && !cmp_acc) |=> st.flag;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("mismatch did not set flag");

   property p_flag_clear;
      @(posedge pclk) disable iff (!presetn)
      (ce && !set_req && wr && idx == `DCC_IDX_FLG2
         && !pwdata[`DCC_B_FLAG]) |=> !st.flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("flag not cleared by write");

   property p_irq_gate;
      @(posedge pclk) disable iff (!presetn)
      (ce && !st.ena) |=> !irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("request raised while disabled");

   property p_irq_raise;
      @(posedge pclk) disable iff (!presetn)
      (ce && st.flag && st.ena && st.intm[`DCC_B_PERIPHERAL_IRQ_ENABLE]
         && st.intm[`DCC_B_GIE]) |=> irq && wake_req;
   endproperty
   a_irq_raise: assert property (p_irq_raise)
      else $error("enabled flag gave no request");

   property p_relatch;
      @(posedge pclk) disable iff (!presetn)
      (ce && cmp_acc) |=> st.seen == $past(cur);
   endproperty
   a_relatch: assert property (p_relatch)
      else $error("access did not relatch results");

   property p_dir_oe;
      @(posedge pclk) disable iff (!presetn)
      (ce && !st.dir[`DCC_PIN_FIVE]) |=> pin_oe[`DCC_PIN_FIVE];
   endproperty
   a_dir_oe: assert property (p_dir_oe)
      else $error("direction bit ignored");

   c_irq: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(irq));
   c_flag_miss: cover property (@(posedge pclk) disable iff (!presetn)
      mism && cmp_acc);
   c_pin_route: cover property (@(posedge pclk) disable iff (!presetn)
      st.route && pin_oe[`DCC_PIN_FOUR]);
endmodule

// *** pkg/dcc_map.svh ***
// Register indices, bit positions and reset values of the comparator block
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH
// Register indices; byte address is four times the index
`define DCC_IDX_PORT 10'h005
`define DCC_IDX_INTM 10'h00B
`define DCC_IDX_FLG2 10'h00D
`define DCC_IDX_DIR 10'h085
`define DCC_IDX_ENA2 10'h08D
`define DCC_IDX_CMP 10'h09C
// Bit positions
`define DCC_B_TWO_RES 7
`define DCC_B_ONE_RES 6
`define DCC_B_TWO_INV 5
`define DCC_B_ONE_INV 4
`define DCC_B_SWITCH 3
`define DCC_B_GIE 7
`define DCC_B_PERIPHERAL_IRQ_ENABLE 6
`define DCC_B_FLAG 6
`define DCC_B_ENA 6
`define DCC_PIN_FOUR 4
`define DCC_PIN_FIVE 5
// Reset values
`define DCC_RST_CMP 8'h07
`define DCC_RST_INTM 8'h00
`define DCC_RST_DIR 6'h3F
`define DCC_RST_PORT 6'h00
// Modes that drive results onto pins four and five
`define DCC_PIN_OUT_MODES 8'h08
`endif

// *** pkg/dcc_pkg.sv ***
// Types shared by the comparator control block
package dcc_pkg;
   typedef enum logic [2:0] {
      DCC_M_000 = 3'b000,
      DCC_M_001 = 3'b001,
      DCC_M_010 = 3'b010,
      DCC_M_011 = 3'b011,
      DCC_M_100 = 3'b100,
      DCC_M_101 = 3'b101,
      DCC_M_REF = 3'b110,
      DCC_M_OFF = 3'b111
   } dcc_mode_t;
endpackage
